// [mprg_rom.v]
// Mask ROM pattern generator with two-phase pin timing and APB access
//
// Summary of operation
// - Nine address inputs, input 1 is the least significant bit.
// - Bits 7 to 9 pick a 64-word set, bits 1 to 6 the word.
// - Nine-bit word on outputs 1 to 9, output 1 the rightmost bit.
// - Negative logic: logical one is LOW, logical zero is HIGH.
// - Each starburst character uses two consecutive words, 128 words in all; the code takes input 5, not input 1, as the second-word select.
// - First character word carries nine segments, second eight; its bit 6 unused.
// - A logical one on a starburst output switches its segment on.
// - Each stroke word holds the next address; fed back it cycles each clock.
// - Stroke words also give four steering outputs for x and y integrators.
// - Sixteen words decode BCD to seven segments plus zero and over-nine flags.
// - Eighty-eight words convert typewriter contact codes to ASCII with parity.
// - Outputs hold while address and inhibit inputs stay unchanged.
// - LOW inhibit turns off both output drivers, leaving outputs floating.
// - First inhibit governs outputs 1 to 5, second governs 6 to 9.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "mprg_defines.vh"

// Operating notes
//
// Pin side
// Every pin input (address, both phases, both inhibits) runs through a
// three-stage synchroniser. A change is only accepted into the filtered
// copy once stages two and three agree, so a single-cycle glitch on a pin
// never reaches the filtered state. The cost is latency: a pin change is
// seen in the filtered state four pclk edges after the pin moves.
//
// Phase one and phase two are active while their pins are LOW. The address
// source is captured as filtered phase one goes inactive, which is why the
// addressing side must keep the address steady through the whole phase:
// the capture edge comes after the pin has already returned HIGH.
//
// The word is looked up from the captured address and loaded into the
// output register as filtered phase two turns active. It then stands until
// the next phase two, whatever the address pins do in between.
//
// Negative logic
// Address pins and data pins are both negative logic: a logical one is a
// LOW pin. The inversion is done once on the way in and once on the way
// out; everything inside the block works on logical values.
//
// Unused bit of the second character word
// When the captured address selects the character area (function select
// bit at logical zero) and the second word of a character (half select bit
// at logical one), output 6 carries no segment and is forced to logical 0,
// whatever the mask holds there.
//
// Output enables
// The inhibit pins act on the enables only, never on the word register, so
// releasing an inhibit shows the word that was already held. The first
// inhibit governs outputs 1 to 5, the second outputs 6 to 9. A user who
// wires outputs together must keep at most one driver enabled per net.
//
// Feedback mode
// With feedback enabled the next address is built from the set base in the
// control register and the low five bits of the current word, so a chain
// stored in the mask advances one word per phase cycle with no help from the
// address pins. The upper outputs are then free for steering signals.
//
// Register side
// The APB slave never inserts wait states. Read data and the error flag are
// prepared in the setup cycle and stand through the access cycle. Unmapped
// offsets return zero with the error flag and ignore writes.
//
// Mask array
// The array is not cleared by reset. Software must load it through the
// index and data registers before the pins are used; each data write
// stores one word and moves the index on by one.
//
// Clock enable
// While the enable is low every register, the synchroniser and the bus
// side are frozen; a bus transfer made then has no effect.

module mprg_rom (
    // Clock, reset and enable
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     ce,
    // APB slave
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`MPRG_PADDR_W-1:0] paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output wire                     pready,
    output reg                      pslverr,
    // Device pins, all at pin level
    input  wire [`MPRG_AW-1:0]      addr_pin_in,
    input  wire                     clock_phase_one,
    input  wire                     clock_phase_two,
    input  wire                     inhibit_low_outputs,
    input  wire                     inhibit_high_outputs,
    output wire [`MPRG_DW-1:0]      data_out_pin,
    output wire [`MPRG_DW-1:0]      data_out_oe
);

    // Mask contents, written by software before use
    reg  [`MPRG_DW-1:0]       mem [0:`MPRG_DEPTH-1];

    reg  [`MPRG_SYNC_W-1:0]   sync1_r;
    reg  [`MPRG_SYNC_W-1:0]   sync2_r;
    reg  [`MPRG_SYNC_W-1:0]   sync3_r;
    reg  [`MPRG_SYNC_W-1:0]   filt_r;
    reg  [`MPRG_SYNC_W-1:0]   filt_nxt;
    reg                       ph1_act_d_r;
    reg                       ph2_act_d_r;

    reg  [7:0]                ctrl_r;
    reg  [`MPRG_AW-1:0]       sw_addr_r;
    reg  [`MPRG_AW-1:0]       rom_index_r;
    reg  [`MPRG_AW-1:0]       cap_addr_r;
    reg  [`MPRG_DW-1:0]       word_r;
    reg  [`MPRG_DW-1:0]       word_nxt;

    wire [`MPRG_SYNC_W-1:0]   pins_raw;
    wire [`MPRG_AW-1:0]       pin_addr_logic;
    wire [`MPRG_AW-1:0]       fb_addr;
    reg  [`MPRG_AW-1:0]       src_addr;
    wire                      ph1_act;
    wire                      ph2_act;
    wire                      ph1_end;
    wire                      ph2_start;
    wire                      setup;
    wire                      access;
    wire                      wr_en;
    wire [`MPRG_DW-1:0]       rd_word;

    // Pin bundle fed through the synchroniser
    assign pins_raw = {inhibit_high_outputs, inhibit_low_outputs,
                       clock_phase_two, clock_phase_one, addr_pin_in};

    // Decides whether an offset is a mapped register
    function is_mapped;
        input [`MPRG_PADDR_W-1:0] a;
        begin
            is_mapped = (a == `MPRG_REG_CTRL) || (a == `MPRG_REG_SW_ADDR) ||
                        (a == `MPRG_REG_ROM_INDEX) || (a == `MPRG_REG_ROM_DATA) ||
                        (a == `MPRG_REG_STATUS);
        end
    endfunction

    // Three-stage synchroniser for every pin input
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= `MPRG_SYNC_RST;
            sync2_r <= `MPRG_SYNC_RST;
            sync3_r <= `MPRG_SYNC_RST;
            filt_r  <= `MPRG_SYNC_RST;
        end else if (ce) begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r  <= filt_nxt;
        end
    end

    // A pin change is accepted once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < `MPRG_SYNC_W; gi = gi + 1) begin : g_filt
            always @* begin
                filt_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : filt_r[gi];
            end
        end
    endgenerate

    // Clock phases are active while the pin is LOW
    assign ph1_act   = ~filt_r[`MPRG_SYNC_PH1];
    assign ph2_act   = ~filt_r[`MPRG_SYNC_PH2];
    assign ph1_end   = ph1_act_d_r & ~ph1_act;
    assign ph2_start = ph2_act & ~ph2_act_d_r;

    // Phase edge detection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph1_act_d_r <= 1'b0;
            ph2_act_d_r <= 1'b0;
        end else if (ce) begin
            ph1_act_d_r <= ph1_act;
            ph2_act_d_r <= ph2_act;
        end
    end

    // Pin address turned into logical bits, bit 0 is input 1
    assign pin_addr_logic = ~filt_r[`MPRG_AW-1:0];

    // Feedback address: set from control, word from the low outputs
    assign fb_addr = {ctrl_r[`MPRG_CTRL_BASE_MSB:`MPRG_CTRL_BASE_LSB],
                      word_r[`MPRG_FB_LOW_MSB:0]};

    // Address source: feedback, then software, then pins
    always @* begin
        if (ctrl_r[`MPRG_CTRL_FB_EN]) begin
            src_addr = fb_addr;
        end else if (ctrl_r[`MPRG_CTRL_SW_SEL]) begin
            src_addr = sw_addr_r;
        end else begin
            src_addr = pin_addr_logic;
        end
    end

    // Address is held through phase one and taken as it closes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_addr_r <= `MPRG_ADDR_RST;
        end else if (ce && ph1_end) begin
            cap_addr_r <= src_addr;
        end
    end

    // Lookup of the captured word; set in bits 8:6, word in bits 5:0
    always @* begin
        word_nxt = mem[cap_addr_r];
        if (!cap_addr_r[`MPRG_FUNC_SEL] && cap_addr_r[`MPRG_WORD_HALF_SEL]) begin
            word_nxt[`MPRG_SECOND_UNUSED] = 1'b0;
        end
    end

    // Word is loaded when phase two begins and then held
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_r <= `MPRG_WORD_RST;
        end else if (ce && ph2_start) begin
            word_r <= word_nxt;
        end
    end

    // Pins show the complement: logical one drives LOW
    assign data_out_pin = ~word_r;

    // Inhibit LOW releases both drivers of its output group
    assign data_out_oe[`MPRG_LOW_GRP_MSB:`MPRG_DATA_OUT_LSB] =
        {(`MPRG_LOW_GRP_MSB + 1){filt_r[`MPRG_SYNC_INH_LO]}};
    assign data_out_oe[`MPRG_DW-1:`MPRG_HIGH_GRP_LSB] =
        {(`MPRG_DW - `MPRG_HIGH_GRP_LSB){filt_r[`MPRG_SYNC_INH_HI]}};

    // APB phases; the slave never waits
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign pready  = 1'b1;
    assign wr_en   = access & pwrite & is_mapped(paddr);
    assign rd_word = mem[rom_index_r];

    // Software registers; data writes advance the index
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r      <= `MPRG_CTRL_RST;
            sw_addr_r   <= `MPRG_ADDR_RST;
            rom_index_r <= `MPRG_ADDR_RST;
        end else if (ce && wr_en) begin
            if (paddr == `MPRG_REG_CTRL) begin
                ctrl_r <= pwdata[7:0];
            end else if (paddr == `MPRG_REG_SW_ADDR) begin
                sw_addr_r <= pwdata[`MPRG_AW-1:0];
            end else if (paddr == `MPRG_REG_ROM_INDEX) begin
                rom_index_r <= pwdata[`MPRG_AW-1:0];
            end else if (paddr == `MPRG_REG_ROM_DATA) begin
                rom_index_r <= rom_index_r + `MPRG_ONE_ADDR;
            end
        end
    end

    // Mask array write port
    always @(posedge pclk) begin
        if (ce && wr_en && (paddr == `MPRG_REG_ROM_DATA)) begin
            mem[rom_index_r] <= pwdata[`MPRG_DW-1:0];
        end
    end

    // Read data and error are prepared in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce && setup) begin
            pslverr <= ~is_mapped(paddr);
            if (pwrite) begin
                prdata <= 32'h00000000;
            end else if (paddr == `MPRG_REG_CTRL) begin
                prdata <= {24'h000000, ctrl_r};
            end else if (paddr == `MPRG_REG_SW_ADDR) begin
                prdata <= {23'h000000, sw_addr_r};
            end else if (paddr == `MPRG_REG_ROM_INDEX) begin
                prdata <= {23'h000000, rom_index_r};
            end else if (paddr == `MPRG_REG_ROM_DATA) begin
                prdata <= {23'h000000, rd_word};
            end else if (paddr == `MPRG_REG_STATUS) begin
                prdata <= {14'h0000, cap_addr_r, word_r};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

endmodule // mprg_rom

// [mprg_defines.vh]
// Constants for the mask ROM pattern generator
`ifndef MPRG_DEFINES_VH
`define MPRG_DEFINES_VH

// Geometry
`define MPRG_AW              9
`define MPRG_DW              9
`define MPRG_DEPTH           512
`define MPRG_DATA_OUT_LSB    0
`define MPRG_LOW_GRP_MSB     4
`define MPRG_HIGH_GRP_LSB    5
`define MPRG_SET_LSB         6

// Address and data bit positions (zero based)
`define MPRG_WORD_HALF_SEL   4
`define MPRG_FUNC_SEL        7
`define MPRG_SECOND_UNUSED   5

// Synchronised pin vector layout
`define MPRG_SYNC_W          13
`define MPRG_SYNC_PH1        9
`define MPRG_SYNC_PH2        10
`define MPRG_SYNC_INH_LO     11
`define MPRG_SYNC_INH_HI     12

// APB register byte offsets
`define MPRG_PADDR_W         8
`define MPRG_REG_CTRL        8'h00
`define MPRG_REG_SW_ADDR     8'h04
`define MPRG_REG_ROM_INDEX   8'h08
`define MPRG_REG_ROM_DATA    8'h0C
`define MPRG_REG_STATUS      8'h10

// Control register fields
`define MPRG_CTRL_SW_SEL     0
`define MPRG_CTRL_FB_EN      1
`define MPRG_CTRL_BASE_LSB   4
`define MPRG_CTRL_BASE_MSB   7
`define MPRG_FB_LOW_MSB      4

// Reset values
`define MPRG_CTRL_RST        8'h00
`define MPRG_ADDR_RST        9'h000
`define MPRG_WORD_RST        9'h000
`define MPRG_SYNC_RST        13'h1FFF
`define MPRG_ONE_ADDR        9'h001

`endif

// [mprg_addr_drv.sv]
// Addressing side model: drives address and two-phase clock pins for one read
`timescale 1ns/1ps
module mprg_addr_drv (
    // Clock, reset and request
    input  wire       pclk,
    input  wire       presetn,
    input  wire       go,
    input  wire [8:0] addr,
    // Pins towards the memory
    output reg  [8:0] addr_pin,
    output reg        ph1_pin,
    output reg        ph2_pin,
    output wire       done
);
    reg  [5:0] cnt_r;
    wire [5:0] cnt_nxt = (go || (cnt_r != 6'h00 && !done)) ? cnt_r + 6'h01 : 6'h00;
    assign done = (cnt_r == 6'h28);
    // Phase one low 1..8, phase two low 17..24; address only valid around phase one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r    <= 6'h00;
            ph1_pin  <= 1'b1;
            ph2_pin  <= 1'b1;
            addr_pin <= 9'h1FF;
        end else begin
            cnt_r    <= cnt_nxt;
            ph1_pin  <= !(cnt_nxt >= 6'h01 && cnt_nxt <= 6'h08);
            ph2_pin  <= !(cnt_nxt >= 6'h11 && cnt_nxt <= 6'h18);
            addr_pin <= (cnt_nxt >= 6'h01 && cnt_nxt <= 6'h0A) ? ~addr : addr;
        end
    end
endmodule // mprg_addr_drv

// [mprg_rom_asserts.sv]
// Concurrent checks on the pattern generator pins and APB port
`timescale 1ns/1ps
`include "mprg_defines.vh"
module mprg_rom_asserts (
    // Clock and reset
    input wire                     pclk,
    input wire                     presetn,
    // APB
    input wire                     psel,
    input wire                     penable,
    input wire                     pwrite,
    input wire [`MPRG_PADDR_W-1:0] paddr,
    input wire [31:0]              prdata,
    input wire                     pready,
    input wire                     pslverr,
    // Pins
    input wire                     clock_phase_two,
    input wire                     inhibit_low_outputs,
    input wire                     inhibit_high_outputs,
    input wire [`MPRG_DW-1:0]      data_out_pin,
    input wire [`MPRG_DW-1:0]      data_out_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Inhibit levels held long enough to pass the pin filter
    sequence s_lo_off; !inhibit_low_outputs [*8]; endsequence
    sequence s_hi_off; !inhibit_high_outputs [*8]; endsequence
    sequence s_unmapped; psel && !penable && paddr > `MPRG_REG_STATUS; endsequence
    chk_reset_idle: assert property ($rose(presetn) |-> data_out_pin == 9'h1FF && data_out_oe == 9'h1FF)
        else $error("pins not idle after reset");
    chk_inh_low_grp: assert property (s_lo_off |-> data_out_oe[4:0] == 5'h00)
        else $error("low group still driven");
    chk_inh_high_grp: assert property (s_hi_off |-> data_out_oe[8:5] == 4'h0)
        else $error("high group still driven");
    chk_low_grp_on: assert property (inhibit_low_outputs [*8] |-> data_out_oe[4:0] == 5'h1F)
        else $error("low group not driven");
    chk_high_grp_on: assert property (inhibit_high_outputs [*8] |-> data_out_oe[8:5] == 4'hF)
        else $error("high group not driven");
    chk_word_hold: assert property (clock_phase_two [*8] |-> $stable(data_out_pin))
        else $error("word changed without phase two");
    chk_err_unmapped: assert property (s_unmapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (psel && !penable && paddr <= `MPRG_REG_STATUS
        && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access refused");
    chk_ready_tied: assert property (psel |-> pready)
        else $error("wait state inserted");
endmodule // mprg_rom_asserts
bind mprg_rom mprg_rom_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .clock_phase_two, .inhibit_low_outputs, .inhibit_high_outputs,
    .data_out_pin, .data_out_oe);

// [mask_rom_pattern_generator_tb_top.sv]
// Self-checking bench for the mask ROM pattern generator
`timescale 1ns/1ps
`include "mprg_defines.vh"
module mask_rom_pattern_generator_tb_top;
    reg          pclk = 1'b0;
    reg          presetn = 1'b0;
    reg          psel = 1'b0;
    reg          penable = 1'b0;
    reg          pwrite = 1'b0;
    reg  [7:0]   paddr = 8'h00;
    reg  [31:0]  pwdata = 32'h0;
    reg          go = 1'b0;
    reg  [8:0]   laddr = 9'h000;
    reg          inh_lo = 1'b1;
    reg          inh_hi = 1'b1;
    wire [31:0]  prdata;
    wire         pready, pslverr, ph1, ph2, done;
    wire [8:0]   apin, dpin, doe;
    logic [31:0] q;
    logic        e;
    integer      bad_count = 0;
    integer      samples_checked = 0;
    integer      i, n;
    // Bus clock
    always #4 pclk = ~pclk;
    mprg_rom dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .addr_pin_in(apin), .clock_phase_one(ph1),
        .clock_phase_two(ph2), .inhibit_low_outputs(inh_lo), .inhibit_high_outputs(inh_hi),
        .data_out_pin(dpin), .data_out_oe(doe));
    mprg_addr_drv u_drv (.pclk, .presetn, .go, .addr(laddr), .addr_pin(apin), .ph1_pin(ph1),
        .ph2_pin(ph2), .done);
    // Verdict and end of run
    task print_verdict;
        begin
            $display("checks %0d errors %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // Compare seen against expected
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // One APB transfer, bounded wait for pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        begin
            psel    <= 1'b1;
            pwrite  <= wr;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 50) begin
                @(posedge pclk);
                n = n + 1;
            end
            q = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
            if (n >= 50) begin
                chk(0, 1);
                print_verdict;
            end
        end
    endtask
    // One two-phase read through the addressing model
    task pin_rd(input logic [8:0] a);
        begin
            laddr <= a;
            go    <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
            n = 0;
            while (done !== 1'b1 && n < 100) begin
                @(posedge pclk);
                n = n + 1;
            end
            if (n >= 100) begin
                chk(0, 1);
                print_verdict;
            end
        end
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk(dpin, 9'h1FF);
        chk(doe, 9'h1FF);
        chk(prdata, 32'h0);
        @(posedge pclk);
        apb(1'b1, `MPRG_REG_ROM_INDEX, 32'h20);
        apb(1'b1, `MPRG_REG_ROM_DATA, 32'h1A1);
        apb(1'b1, `MPRG_REG_ROM_DATA, 32'h1A2);
        apb(1'b1, `MPRG_REG_ROM_DATA, 32'h1A0);
        apb(1'b1, `MPRG_REG_ROM_INDEX, 32'h30);
        apb(1'b1, `MPRG_REG_ROM_DATA, 32'h1FF);
        apb(1'b1, `MPRG_REG_ROM_INDEX, 32'h21);
        for (i = 0; i < 2; i = i + 1) begin
            apb(1'b0, `MPRG_REG_ROM_DATA, 32'h0);
            chk(q, 32'h1A2);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk(e, 1'b1);
        chk(q, 32'h0);
        // Pins are negative logic, so the stored word shows inverted
        pin_rd(9'h021);
        chk(dpin, 9'h05D);
        // Feedback steps through the chain one word per cycle
        apb(1'b1, `MPRG_REG_CTRL, 32'h12);
        pin_rd(9'h000);
        chk(dpin, 9'h05F);
        pin_rd(9'h000);
        chk(dpin, 9'h05E);
        apb(1'b1, `MPRG_REG_CTRL, 32'h00);
        // ASCII 0x41: b1 to address 4, b7 to address 7, logical 0x048
        apb(1'b1, `MPRG_REG_ROM_INDEX, 32'h48);
        apb(1'b1, `MPRG_REG_ROM_DATA, 32'h155);
        pin_rd({2'b00, 1'b1, 1'b0, 1'b0, 1'b1, 3'b000});
        chk(dpin, 9'h0AA);
        pin_rd(9'h030);
        chk(dpin, 9'h020);
        // Every inhibit combination, word must not move
        for (i = 0; i < 4; i = i + 1) begin
            inh_lo <= i[0];
            inh_hi <= i[1];
            repeat (10) @(posedge pclk);
            chk(doe, {{4{i[1]}}, {5{i[0]}}});
            chk(dpin, 9'h020);
        end
        print_verdict;
    end
endmodule // mask_rom_pattern_generator_tb_top
